// file: inc/occ_map.svh
// register offsets, field positions and reset values of the output control
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
`define OCC_N_OUT 7
`define OCC_N_LOOP 3
`define OCC_N_PIN 3
`define OCC_DIV_W 16
`define OCC_ADDR_W 8
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OCC_OFF_CTRL 8'h00
`define OCC_OFF_REG_EN 8'h04
`define OCC_OFF_LOL_DIS 8'h08
`define OCC_OFF_DIS_HIGH 8'h0c
`define OCC_OFF_SYNC_DIS 8'h10
`define OCC_OFF_SE_MODE 8'h14
`define OCC_OFF_XPOINT 8'h18
`define OCC_OFF_OE_MAP 8'h1c
`define OCC_OFF_POLARITY 8'h20
`define OCC_OFF_DRIVE 8'h24
`define OCC_OFF_LOW_SUPPLY 8'h28
`define OCC_OFF_MISC 8'h2c
`define OCC_OFF_STATUS 8'h30
`define OCC_OFF_DIV0 8'h40
`define OCC_N_CFG 12
// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define OCC_CTRL_HARD_RST 0
`define OCC_CTRL_XTAL_KEEP 1
`define OCC_CTRL_CASCADE 2
`define OCC_CTRL_MASK 32'h0000_0006
// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define OCC_RST_REG_EN 32'h0000_007f
`define OCC_RST_SYNC_DIS 32'h0000_007f
`define OCC_RST_DRIVE 32'h0000_3fff
`define OCC_RST_ZERO 32'h0000_0000
`define OCC_MASK_7 32'h0000_007f
`define OCC_MASK_14 32'h0000_3fff
`define OCC_MASK_DIV 32'h0000_ffff
`define OCC_SEL_NONE 2'h3
`define OCC_DRIVE_WEAK 2'h1
`define OCC_DRIVE_MID 2'h2
`define OCC_RESP_OKAY 2'h0
`define OCC_RESP_SLVERR 2'h2
`endif

// file: inc/occ_pkg.sv
// types shared by the output clock enable control
package occ_pkg;
   // per-output configuration carried to each driver
   typedef struct packed {
      logic [1:0] loop_sel;
      logic [1:0] oe_sel;
      logic reg_en;
      logic lol_dis;
      logic dis_high;
      logic sync_dis;
      logic se_mode;
      logic inv_comp;
      logic inv_true;
      logic [1:0] drive;
      logic low_supply;
      logic [15:0] div_half;
   } occ_out_cfg_t;
   // the two pins of one output driver
   typedef struct packed {
      logic out_true_pin;
      logic out_complement_pin;
   } occ_pin_t;
endpackage : occ_pkg

// file: src/occ_out_driver.sv
// one output driver: r divider, enable gating, polarity and drive code
`include "occ_map.svh"
module occ_out_driver
   import occ_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic div_rst,
   input wire logic tick,
   input wire logic enable_ok,
   input wire occ_out_cfg_t cfg,
   output occ_pin_t pins,
   output logic [1:0] single_ended_drive_code,
   output logic active,
   output logic rise_tick
);
   logic [`OCC_DIV_W-1:0] cnt_q;
   logic phase_q;
   logic active_q;
   logic active_d;
   logic term;
   logic clk_t;
   logic comp_lvl;
   occ_pin_t pins_q;
   occ_pin_t pins_d;
   logic [1:0] drive_q;
   logic [1:0] drive_d;

   // ----------------------------------------------------------------
   // divider and disable decision
   // ----------------------------------------------------------------
   assign term = tick && (cnt_q == cfg.div_half);
   assign rise_tick = term && !phase_q;
   // sync mode only switches at the end of a whole period
   assign active_d = cfg.sync_dis ? (rise_tick ? enable_ok : active_q)
                                  : enable_ok;

   // divider is forced to a known phase on any divider reset
   always_ff @(posedge aclk) begin
      if (!aresetn || div_rst) begin
         cnt_q <= '0;
         phase_q <= 1'b0;
         active_q <= 1'b0;
      end else begin
         active_q <= active_d;
         if (term) begin
            cnt_q <= '0;
            phase_q <= !phase_q;
         end else if (tick) begin
            cnt_q <= cnt_q + `OCC_DIV_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // pin levels and drive code
   // ----------------------------------------------------------------
   assign clk_t = phase_q ^ cfg.inv_true;
   // single-ended: in phase by default, inverted on request
   assign comp_lvl = cfg.se_mode ? clk_t ^ cfg.inv_comp : !clk_t;
   assign pins_d.out_true_pin = active_q ? clk_t : cfg.dis_high;
   assign pins_d.out_complement_pin = active_q ? comp_lvl
      : (cfg.se_mode ? cfg.dis_high : !cfg.dis_high);
   // weakest code is not offered on the lowest supply
   assign drive_d = (cfg.drive == 2'h0 ||
      (cfg.drive == `OCC_DRIVE_WEAK && cfg.low_supply)) ? `OCC_DRIVE_MID
      : cfg.drive;

   // registered pin and drive outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_q <= '0;
         drive_q <= `OCC_DRIVE_MID;
      end else begin
         pins_q <= pins_d;
         drive_q <= drive_d;
      end
   end

   assign pins = pins_q;
   assign single_ended_drive_code = drive_q;
   assign active = active_q;
endmodule : occ_out_driver

// file: src/occ_top.sv
// output clock enable control with an axi4-lite register slave
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "occ_map.svh"
// Function
// - seven output drivers, each controlled by enable, polarity and disable.
// - crosspoint routes each output to any of three synthesis loops.
// - any driver can be single-ended, two separate clocks per driver.
// - single-ended complement pin in phase by default, polarity settable.
// - three enable pins, register map assigns each output to one.
// - default map: pin zero controls all, pins one and two unmapped.
// - register enable can disable an output the pin allows.
// - register enables reset to not disable any output.
// - unlocked loop keeps outputs running unless its disable option set.
// - crystal loss disables all outputs unless the keep option set.
// - disabled output holds static low or high per register.
// - synchronous disable waits until the current period completes.
// - asynchronous disable turns the output off at once.
// - dividers reset at power-up, external reset pin or hard reset bit.
// - output six can cascade dividers five and six for one hertz.
// - drive code 1, 2 or 3; code 1 refused on lowest supply.
// - each loop presents a loss-of-lock indication feeding the disable.
module occ_top
   import occ_pkg::*;
#(
   parameter int N_OUT = `OCC_N_OUT,
   parameter int N_LOOP = `OCC_N_LOOP
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`OCC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`OCC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [N_LOOP-1:0] loop_clk,
   input wire logic [N_LOOP-1:0] loop_unlocked,
   input wire logic crystal_loss_alarm,
   input wire logic enable_pin_zero_n,
   input wire logic enable_pin_one_n,
   input wire logic enable_pin_two_n,
   input wire logic external_reset_n,
   output occ_pin_t [N_OUT-1:0] out_pins,
   output logic [N_OUT-1:0][1:0] single_ended_drive_code
);
   localparam int N_ASYNC = 2 * N_LOOP + 5;

   // ----------------------------------------------------------------
   // address decode helpers
   // ----------------------------------------------------------------
   function automatic logic cfg_hit(input logic [`OCC_ADDR_W-1:0] a);
      cfg_hit = (a[7:6] == 2'h0) && (a[5:2] < 4'(`OCC_N_CFG));
   endfunction : cfg_hit

   function automatic logic div_hit(input logic [`OCC_ADDR_W-1:0] a);
      div_hit = (a[7:5] == 3'h2) && (a[4:2] < 3'(N_OUT));
   endfunction : div_hit

   function automatic logic [31:0] cfg_mask(input logic [3:0] i);
      unique case (i)
         4'h0: cfg_mask = `OCC_CTRL_MASK;
         4'h6, 4'h7, 4'h8, 4'h9: cfg_mask = `OCC_MASK_14;
         4'hb: cfg_mask = `OCC_RST_ZERO;
         default: cfg_mask = `OCC_MASK_7;
      endcase
   endfunction : cfg_mask

   function automatic logic [31:0] cfg_init(input logic [3:0] i);
      unique case (i)
         4'h1: cfg_init = `OCC_RST_REG_EN;
         4'h4: cfg_init = `OCC_RST_SYNC_DIS;
         4'h9: cfg_init = `OCC_RST_DRIVE;
         default: cfg_init = `OCC_RST_ZERO;
      endcase
   endfunction : cfg_init

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [N_ASYNC-1:0] async_in;
   logic [N_ASYNC-1:0] sync1_q;
   logic [N_ASYNC-1:0] sync2_q;
   logic [N_LOOP-1:0] loop_prev_q;
   logic [N_LOOP-1:0] loop_clk_s;
   logic [N_LOOP-1:0] loop_tick;
   logic [N_LOOP-1:0] unlocked_s;
   logic [2:0] pin_n_s;
   logic xtal_loss_s;
   logic ext_rst_n_s;

   assign async_in = {external_reset_n, crystal_loss_alarm,
      enable_pin_two_n, enable_pin_one_n, enable_pin_zero_n,
      loop_unlocked, loop_clk};
   assign loop_clk_s = sync2_q[N_LOOP-1:0];
   assign unlocked_s = sync2_q[2*N_LOOP-1:N_LOOP];
   assign pin_n_s = sync2_q[2*N_LOOP+2:2*N_LOOP];
   assign xtal_loss_s = sync2_q[2*N_LOOP+3];
   assign ext_rst_n_s = sync2_q[2*N_LOOP+4];
   assign loop_tick = loop_clk_s & ~loop_prev_q;

   // two-stage synchroniser, then loop clock edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '1;
         sync2_q <= '1;
         loop_prev_q <= '1;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
         loop_prev_q <= loop_clk_s;
      end
   end

   // ----------------------------------------------------------------
   // register storage and axi4-lite write path
   // ----------------------------------------------------------------
   logic [31:0] cfg_q [`OCC_N_CFG];
   logic [`OCC_DIV_W-1:0] div_q [N_OUT];
   logic aw_have_q;
   logic w_have_q;
   logic [`OCC_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_go;
   logic [31:0] be_mask;
   logic [3:0] wr_idx;
   logic hard_rst_q;

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;
   assign wr_idx = awaddr_q[5:2];
   assign be_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
      {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // address and data are taken in either order, answered once both held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= `OCC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (cfg_hit(awaddr_q) || div_hit(awaddr_q) ||
               awaddr_q == `OCC_OFF_STATUS) ? `OCC_RESP_OKAY
               : `OCC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // configuration registers, masked by byte strobes and field widths
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < `OCC_N_CFG; i++) begin
            cfg_q[i] <= cfg_init(4'(i));
         end
         for (int i = 0; i < N_OUT; i++) begin
            div_q[i] <= '0;
         end
         hard_rst_q <= 1'b0;
      end else begin
         // hard reset bit self-clears after one cycle
         hard_rst_q <= wr_go && cfg_hit(awaddr_q) && wr_idx == 4'h0 &&
            wstrb_q[0] && wdata_q[`OCC_CTRL_HARD_RST];
         if (wr_go && cfg_hit(awaddr_q)) begin
            cfg_q[wr_idx] <= (cfg_q[wr_idx] & ~(be_mask & cfg_mask(wr_idx)))
               | (wdata_q & be_mask & cfg_mask(wr_idx));
         end
         if (wr_go && div_hit(awaddr_q)) begin
            div_q[awaddr_q[4:2]] <= (div_q[awaddr_q[4:2]]
               & ~be_mask[`OCC_DIV_W-1:0])
               | (wdata_q[`OCC_DIV_W-1:0] & be_mask[`OCC_DIV_W-1:0]);
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic [N_OUT-1:0] active;

   assign status_word = {17'h0, ext_rst_n_s, pin_n_s, xtal_loss_s,
      unlocked_s, active};
   assign rd_ok = cfg_hit(s_axi_araddr) || div_hit(s_axi_araddr) ||
      s_axi_araddr == `OCC_OFF_STATUS;
   assign rd_mux = cfg_hit(s_axi_araddr) ? cfg_q[s_axi_araddr[5:2]]
      : div_hit(s_axi_araddr) ? {16'h0, div_q[s_axi_araddr[4:2]]}
      : (s_axi_araddr == `OCC_OFF_STATUS) ? status_word : 32'h0;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // one read in flight; data held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `OCC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_ok ? `OCC_RESP_OKAY : `OCC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // enable combination and output drivers
   // ----------------------------------------------------------------
   occ_out_cfg_t [N_OUT-1:0] out_cfg;
   logic [N_OUT-1:0] enable_ok;
   logic [N_OUT-1:0] drv_tick;
   logic [N_OUT-1:0] rise_tick;
   logic div_rst;
   logic xtal_kill;

   // divider reset on external pin or hard reset bit
   assign div_rst = !ext_rst_n_s || hard_rst_q;
   assign xtal_kill = xtal_loss_s && !cfg_q[0][`OCC_CTRL_XTAL_KEEP];

   generate
      for (genvar i = 0; i < N_OUT; i++) begin : g_out
         logic [1:0] lsel;
         logic pin_ok;
         assign out_cfg[i].loop_sel = cfg_q[6][2*i+:2];
         assign out_cfg[i].oe_sel = cfg_q[7][2*i+:2];
         assign out_cfg[i].reg_en = cfg_q[1][i];
         assign out_cfg[i].lol_dis = cfg_q[2][i];
         assign out_cfg[i].dis_high = cfg_q[3][i];
         assign out_cfg[i].sync_dis = cfg_q[4][i];
         assign out_cfg[i].se_mode = cfg_q[5][i];
         assign out_cfg[i].inv_comp = cfg_q[8][2*i];
         assign out_cfg[i].inv_true = cfg_q[8][2*i+1];
         assign out_cfg[i].drive = cfg_q[9][2*i+:2];
         assign out_cfg[i].low_supply = cfg_q[10][i];
         assign out_cfg[i].div_half = div_q[i];
         // code 3 has no loop behind it and falls back to loop 0
         assign lsel = (out_cfg[i].loop_sel == 2'h3) ? 2'h0
            : out_cfg[i].loop_sel;
         // unmapped outputs ignore the pins entirely
         assign pin_ok = (out_cfg[i].oe_sel == `OCC_SEL_NONE) ? 1'b1
            : !pin_n_s[out_cfg[i].oe_sel];
         assign enable_ok[i] = pin_ok && out_cfg[i].reg_en
            && !(out_cfg[i].lol_dis && unlocked_s[lsel])
            && !xtal_kill;
         if (i == N_OUT - 1) begin : g_cascade
            // last output may count divider five's periods instead
            assign drv_tick[i] = cfg_q[0][`OCC_CTRL_CASCADE] ?
               rise_tick[i-1] : loop_tick[lsel];
         end else begin : g_direct
            assign drv_tick[i] = loop_tick[lsel];
         end
         occ_out_driver u_drv (
            .aclk(aclk),
            .aresetn(aresetn),
            .div_rst(div_rst),
            .tick(drv_tick[i]),
            .enable_ok(enable_ok[i]),
            .cfg(out_cfg[i]),
            .pins(out_pins[i]),
            .single_ended_drive_code(single_ended_drive_code[i]),
            .active(active[i]),
            .rise_tick(rise_tick[i])
         );
      end
   endgenerate
endmodule : occ_top

// file: tb/occ_asserts.sv
// port checks for the output clock enable control
module occ_asserts
   import occ_pkg::*;
#(
   parameter int N_OUT = 7
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire occ_pin_t [N_OUT-1:0] out_pins,
   input wire logic [N_OUT-1:0][1:0] single_ended_drive_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // checks
   // ----------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic code_zero;
   // raised when any output reports drive code zero
   always_comb begin
      code_zero = 1'h0;
      for (int i = 0; i < N_OUT; i++) begin
         if (single_ended_drive_code[i] == 2'h0) begin
            code_zero = 1'h1;
         end
      end
   end
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
   aw_block_a: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
   write_lat_a: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   read_lat_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   rresp_code_a: assert property (s_axi_rvalid
      |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("bad rresp");
   drive_nonzero_a: assert property (!code_zero)
      else $error("drive code zero");
   reset_pins_a: assert property (disable iff (1'h0) !aresetn
      |=> out_pins == '0) else $error("pins not low in reset");
   reset_drive_a: assert property (disable iff (1'h0) !aresetn
      |=> single_ended_drive_code == {N_OUT{2'h2}})
      else $error("drive code not two in reset");
endmodule : occ_asserts

bind occ_top occ_asserts #(.N_OUT(N_OUT)) occ_asserts_inst (.*);

// file: tb/occ_partner.sv
// downstream device: holds the enable pins, counts output edges
module occ_partner
   import occ_pkg::*;
(
   input wire logic aclk,
   input wire logic clr,
   input wire logic [2:0] hold_req,
   input wire occ_pin_t [6:0] out_pins,
   output logic enable_pin_zero_n,
   output logic enable_pin_one_n,
   output logic enable_pin_two_n,
   output logic [6:0][7:0] rise_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] true_q;
   // a pin is pulled low only while the bench asks for it
   assign enable_pin_zero_n = !hold_req[0];
   assign enable_pin_one_n = !hold_req[1];
   assign enable_pin_two_n = !hold_req[2];
   // rising edges of each true pin since the last clear
   always @(posedge aclk) begin
      for (int i = 0; i < 7; i++) begin
         true_q[i] <= out_pins[i].out_true_pin;
         if (clr) begin
            rise_cnt[i] <= 8'h00;
         end else if (out_pins[i].out_true_pin && !true_q[i]) begin
            rise_cnt[i] <= rise_cnt[i] + 8'h01;
         end
      end
   end
endmodule : occ_partner

// file: tb/tb_top.sv
// self-checking bench for the output clock enable control
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import occ_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] loop_clk = 3'h0, loop_unlocked = 3'h0, hold_req = 3'h0;
   logic crystal_loss_alarm = 1'h0, external_reset_n = 1'h1, clr = 1'h0;
   logic enable_pin_zero_n, enable_pin_one_n, enable_pin_two_n;
   occ_pin_t [6:0] out_pins;
   logic [6:0][1:0] single_ended_drive_code;
   logic [6:0][7:0] rise_cnt;
   int errors = 0, n_checks = 0, lc = 0;
   occ_top occ_top_inst (.*);
   occ_partner occ_partner_inst (.*);
   // ----------------
   // clock, loop clocks, compares, bus
   // ----------------
   initial begin
      forever #2 aclk = !aclk;
   end
   // loop clocks with half periods of 10, 20 and 30 cycles
   always @(posedge aclk) begin
      lc <= lc + 1;
      for (int i = 0; i < 3; i++) begin
         if (lc % (10 * (i + 1)) == 0) begin
            loop_clk[i] <= !loop_clk[i];
         end
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rng(input logic [7:0] got, input int lo, input int hi);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'h1) begin
         errors++;
         $display("BAD %0t count %0d not %0d..%0d", $time, got, lo, hi);
      end
   endtask : rng
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = 2'h0);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while ((s_axi_awvalid && !s_axi_awready)
         || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h1;
      @(posedge aclk);
      s_axi_bready <= 1'h0;
      chk(32'(s_axi_bresp), 32'(r));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = 2'h0);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h1;
      @(posedge aclk);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, d);
      chk(32'(s_axi_rresp), 32'(r));
   endtask : rd
   // clear the edge counts, then let n cycles pass
   task automatic run(input int n);
      clr <= 1'h1;
      @(posedge aclk);
      clr <= 1'h0;
      repeat (n) @(posedge aclk);
   endtask : run
   // complement pin of output 0 against the true pin, inverted by x
   task automatic scan(input logic x);
      int bad;
      bad = 0;
      repeat (100) begin
         @(posedge aclk);
         if (out_pins[0].out_complement_pin
            !== (out_pins[0].out_true_pin ^ x)) bad++;
      end
      chk(bad, 0);
   endtask : scan
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   // ----------------
   // scenarios
   // ----------------
   task automatic t_regs();
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h7f);
      rd(8'h10, 32'h7f);
      rd(8'h1c, 32'h0);
      rd(8'h24, 32'h3fff);
      rd(8'h3c, 32'h0, 2'h2);
      wr(8'h3c, 32'h1, 2'h2);
      wr(8'h08, 32'hff);
      rd(8'h08, 32'h7f);
      wr(8'h08, 32'h0);
   endtask : t_regs
   task automatic t_pins();
      run(200);
      rng(rise_cnt[0], 0, 0);
      hold_req <= 3'h2;
      run(200);
      rng(rise_cnt[6], 0, 0);
      hold_req <= 3'h1;
      run(400);
      for (int i = 0; i < 7; i++) rng(rise_cnt[i], 8, 11);
   endtask : t_pins
   task automatic t_regen();
      wr(8'h0c, 32'h1);
      wr(8'h04, 32'h7e);
      run(200);
      rng(rise_cnt[0], 0, 1);
      chk(32'(out_pins[0]), 32'h2);
      wr(8'h14, 32'h1);
      run(3);
      chk(32'(out_pins[0]), 32'h3);
      wr(8'h14, 32'h0);
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'h7f);
   endtask : t_regen
   task automatic t_alarm();
      crystal_loss_alarm <= 1'h1;
      run(200);
      rng(rise_cnt[3], 0, 1);
      wr(8'h00, 32'h2);
      run(200);
      rng(rise_cnt[3], 3, 6);
      crystal_loss_alarm <= 1'h0;
      wr(8'h00, 32'h0);
   endtask : t_alarm
   task automatic t_lol();
      loop_unlocked <= 3'h1;
      run(200);
      rng(rise_cnt[0], 3, 6);
      rd(8'h30, 32'h70ff);
      wr(8'h08, 32'h7f);
      run(200);
      rng(rise_cnt[0], 0, 1);
      loop_unlocked <= 3'h0;
      run(200);
      rng(rise_cnt[0], 3, 6);
      wr(8'h08, 32'h0);
   endtask : t_lol
   task automatic t_map();
      wr(8'h1c, 32'hb4);
      run(400);
      rng(rise_cnt[1], 0, 1);
      rng(rise_cnt[2], 8, 11);
      hold_req <= 3'h2;
      run(400);
      rng(rise_cnt[1], 8, 11);
      rng(rise_cnt[0], 0, 1);
      rng(rise_cnt[3], 0, 1);
      hold_req <= 3'h4;
      run(400);
      rng(rise_cnt[3], 8, 11);
      rng(rise_cnt[2], 8, 11);
      wr(8'h04, 32'h7b);
      run(200);
      rng(rise_cnt[2], 0, 1);
      wr(8'h04, 32'h7f);
      wr(8'h1c, 32'h0);
      hold_req <= 3'h1;
   endtask : t_map
   task automatic t_xpt();
      wr(8'h18, 32'h270);
      wr(8'h00, 32'h4);
      run(400);
      rng(rise_cnt[2], 9, 11);
      rng(rise_cnt[3], 4, 6);
      rng(rise_cnt[4], 2, 4);
      rng(rise_cnt[5], 9, 11);
      rng(rise_cnt[6], 4, 6);
      wr(8'h18, 32'h0);
      wr(8'h00, 32'h0);
   endtask : t_xpt
   task automatic t_pol();
      wr(8'h14, 32'h7f);
      scan(1'h0);
      wr(8'h20, 32'h1);
      scan(1'h1);
      wr(8'h14, 32'h0);
      scan(1'h1);
      wr(8'h20, 32'h0);
   endtask : t_pol
   task automatic t_drive();
      wr(8'h24, 32'h0);
      run(3);
      chk(32'(single_ended_drive_code), 32'h2aaa);
      wr(8'h24, 32'h1555);
      run(3);
      chk(32'(single_ended_drive_code), 32'h1555);
      wr(8'h28, 32'h7f);
      run(3);
      chk(32'(single_ended_drive_code), 32'h2aaa);
      wr(8'h24, 32'h3fff);
      run(3);
      chk(32'(single_ended_drive_code), 32'h3fff);
      wr(8'h28, 32'h0);
   endtask : t_drive
   task automatic t_dis();
      wr(8'h10, 32'h0);
      @(posedge out_pins[0].out_true_pin);
      @(posedge aclk);
      hold_req <= 3'h0;
      repeat (8) @(posedge aclk);
      chk(32'(out_pins[0]), 32'h1);
      hold_req <= 3'h1;
      wr(8'h10, 32'h7f);
      @(posedge out_pins[0].out_true_pin);
      @(posedge aclk);
      hold_req <= 3'h0;
      repeat (8) @(posedge aclk);
      chk(32'(out_pins[0]), 32'h2);
      repeat (60) @(posedge aclk);
      chk(32'(out_pins[0]), 32'h1);
      hold_req <= 3'h1;
   endtask : t_dis
   task automatic t_rst();
      external_reset_n <= 1'h0;
      run(200);
      rng(rise_cnt[0], 0, 1);
      chk(32'(out_pins[0]), 32'h1);
      external_reset_n <= 1'h1;
      wr(8'h00, 32'h1);
      rd(8'h00, 32'h0);
      run(400);
      rng(rise_cnt[0], 8, 11);
   endtask : t_rst
   // main sequence
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_pins();
      t_regen();
      t_alarm();
      t_lol();
      t_map();
      t_xpt();
      t_pol();
      t_drive();
      t_dis();
      t_rst();
      summarize();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      summarize();
   end
endmodule : tb_top
